// file: rtl/mtel_params.svh
// offsets, field positions, reset values and code points of the telemetry bank
`ifndef MTEL_PARAMS_SVH
`define MTEL_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define MTEL_IDX_STATE 14'h190
`define MTEL_IDX_SPEED 14'h196
`define MTEL_IDX_BUS_CUR 14'h410
`define MTEL_IDX_PHASE_A 14'h440
`define MTEL_IDX_PHASE_B 14'h442
`define MTEL_IDX_IRQ_STATUS 14'h7f0
`define MTEL_IDX_IRQ_MASK 14'h7f1
`define MTEL_IDX_CTRL 14'h7f2
`define MTEL_IDX_UPD_COUNT 14'h7f3

// widths
`define MTEL_ADR_W 16
`define MTEL_CODE_W 16
`define MTEL_EV_W 4

// reset values
`define MTEL_RST_CODE 16'h0000
`define MTEL_RST_WORD 32'h0000_0000
`define MTEL_RST_EV 4'h0
`define MTEL_RST_CNT 16'h0000

// operating state code points that raise events
`define MTEL_CODE_IDLE 16'h0000
`define MTEL_CODE_FAULT 16'h000e
`define MTEL_CODE_MEAS_FAULT 16'h0018

// interrupt status / mask bit positions
`define MTEL_EV_UPDATE 0
`define MTEL_EV_STATE_CHG 1
`define MTEL_EV_FAULT 2
`define MTEL_EV_DROPPED 3

// control register field positions
`define MTEL_CTRL_FREEZE 0
`endif

// file: rtl/mtel_pkg.sv
// types and address decode shared by the telemetry bank modules
`default_nettype none
`include "mtel_params.svh"
package mtel_pkg;
    typedef enum logic [3:0] {
        MTEL_REG_NONE,
        MTEL_REG_STATE,
        MTEL_REG_SPEED,
        MTEL_REG_BUS_CUR,
        MTEL_REG_PHASE_A,
        MTEL_REG_PHASE_B,
        MTEL_REG_IRQ_STATUS,
        MTEL_REG_IRQ_MASK,
        MTEL_REG_CTRL,
        MTEL_REG_UPD_COUNT
    } mtel_reg_e;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } mtel_wb_s;

    typedef struct packed {
        logic [`MTEL_EV_W-1:0] status;
        logic [`MTEL_EV_W-1:0] mask;
        logic irq;
    } mtel_irq_s;

    typedef struct packed {
        logic [`MTEL_CODE_W-1:0] code;
        logic [31:0] speed;
        logic [31:0] bus_cur;
        logic [31:0] phase_a;
        logic [31:0] phase_b;
        logic freeze;
        logic [15:0] upd_cnt;
    } mtel_core_s;

    // byte address to register; misaligned or unknown gives none
    function automatic mtel_reg_e mtel_decode(input logic [`MTEL_ADR_W-1:0] a);
        if (a[1:0] != 2'h0) begin
            return MTEL_REG_NONE;
        end
        unique case (a[`MTEL_ADR_W-1:2])
            `MTEL_IDX_STATE: return MTEL_REG_STATE;
            `MTEL_IDX_SPEED: return MTEL_REG_SPEED;
            `MTEL_IDX_BUS_CUR: return MTEL_REG_BUS_CUR;
            `MTEL_IDX_PHASE_A: return MTEL_REG_PHASE_A;
            `MTEL_IDX_PHASE_B: return MTEL_REG_PHASE_B;
            `MTEL_IDX_IRQ_STATUS: return MTEL_REG_IRQ_STATUS;
            `MTEL_IDX_IRQ_MASK: return MTEL_REG_IRQ_MASK;
            `MTEL_IDX_CTRL: return MTEL_REG_CTRL;
            `MTEL_IDX_UPD_COUNT: return MTEL_REG_UPD_COUNT;
            default: return MTEL_REG_NONE;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: rtl/mtel_bus_if.sv
// internal access and event carrier between front end, core and interrupt block
`timescale 1ns/10ps
`default_nettype none
interface mtel_bus_if;
    logic wr_stb;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [3:0] sel;
    logic [31:0] rdata;
    logic [3:0] ev;
    logic [3:0] status;
    logic [3:0] mask;

    modport front (output wr_stb, output addr, output wdata, output sel, input rdata);
    modport core (input wr_stb, input addr, input wdata, input sel, input status,
                  input mask, output rdata, output ev);
    modport irq (input wr_stb, input addr, input wdata, input sel, input ev,
                 output status, output mask);
endinterface
`default_nettype wire

// file: rtl/mtel_wb_front.sv
// classic wishbone slave front end: single ack per request, registered read data
`timescale 1ns/10ps
`default_nettype none
`include "mtel_params.svh"
module mtel_wb_front
    import mtel_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    mtel_bus_if.front bus
);
    mtel_wb_s st_r;
    mtel_wb_s st_nxt;

    // request fields pass straight through; master holds them until ack
    assign bus.addr = wb_adr_i;
    assign bus.wdata = wb_dat_i;
    assign bus.sel = wb_sel_i;
    // write lands on the edge where the master sees ack, exactly once
    assign bus.wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & st_r.ack;

    // ack one cycle after request, dropped the next cycle
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        if (st_nxt.ack) begin
            st_nxt.dat = wb_we_i ? `MTEL_RST_WORD : bus.rdata; // whole word in one edge
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{ack: 1'b0, dat: `MTEL_RST_WORD};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
endmodule
`default_nettype wire

// file: rtl/mtel_irq.sv
// sticky event status, write-one-to-clear, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
`include "mtel_params.svh"
module mtel_irq
    import mtel_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    output logic irq_o,
    mtel_bus_if.irq bus
);
    mtel_irq_s st_r;
    mtel_irq_s st_nxt;
    logic [3:0] clr;

    // clear only lanes software writes; a new event in the same cycle wins
    always_comb begin
        st_nxt = st_r;
        clr = 4'h0;
        if (bus.wr_stb && bus.sel[0]) begin
            if (mtel_decode(bus.addr) == MTEL_REG_IRQ_STATUS) begin
                clr = bus.wdata[3:0];
            end
            if (mtel_decode(bus.addr) == MTEL_REG_IRQ_MASK) begin
                st_nxt.mask = bus.wdata[3:0];
            end
        end
        st_nxt.status = (st_r.status & ~clr) | bus.ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{status: `MTEL_RST_EV, mask: `MTEL_RST_EV, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.status = st_r.status;
    assign bus.mask = st_r.mask;
    assign irq_o = st_r.irq;
endmodule
`default_nettype wire

// file: rtl/mtel_top.sv
// motor algorithm telemetry register bank with wishbone access and interrupt
//
// How it works
// - 16-bit read-only operating state code, 0h idle up to 18h measure fault.
// - 32-bit read-only rotor speed, hertz = value / 2^27 * max speed.
// - 32-bit read-only supply bus current, value / 2^27 * base current / 8.
// - 32-bit read-only first phase current, same 2^27 and /8 scaling.
// - second phase current at index 442h, 32-bit read-only, zero after reset.
// - every register of the bank reads zero after reset until first update; mask and control until software writes them.
// - state code at index 190h, rotor speed at 196h, both zero after reset.
// - second phase current scaled like the first phase.
//
// the control algorithm delivers all five values together with a one-cycle
// update strobe; the bank captures them all on the same edge.  software may
// freeze the snapshot to read several words from one update; updates arriving
// while frozen are dropped and flagged.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "mtel_params.svh"
module mtel_top
    import mtel_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic alg_upd_i,
    input wire logic [15:0] alg_state_i,
    input wire logic [31:0] alg_speed_i,
    input wire logic [31:0] alg_bus_cur_i,
    input wire logic [31:0] alg_phase_a_i,
    input wire logic [31:0] alg_phase_b_i
);
    mtel_bus_if bus ();

    mtel_core_s st_r;
    mtel_core_s st_nxt;
    mtel_reg_e rd_sel;
    mtel_reg_e wr_sel;
    logic upd_take;
    logic upd_drop;
    logic code_chg;
    logic fault_in;
    logic [3:0] ev;

    // a fault code is either the run-time fault or the measurement fault
    function automatic logic is_fault(input logic [15:0] code);
        return (code == `MTEL_CODE_FAULT) || (code == `MTEL_CODE_MEAS_FAULT);
    endfunction

    // zero-extend the 16-bit state code; upper half reads as zero
    function automatic logic [31:0] widen_code(input logic [15:0] code);
        return {16'h0000, code};
    endfunction

    // wishbone front end: ack and read data registers
    mtel_wb_front u_front (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .bus(bus.front)
    );

    // sticky status, mask and interrupt line
    mtel_irq u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .irq_o(irq_o),
        .bus(bus.irq)
    );

    // update strobe qualified by the freeze control
    always_comb begin
        upd_take = alg_upd_i & ~st_r.freeze;
        upd_drop = alg_upd_i & st_r.freeze;
        code_chg = upd_take && (alg_state_i != st_r.code);
        fault_in = code_chg && is_fault(alg_state_i);
    end

    // event vector into the sticky status bits
    always_comb begin
        ev = `MTEL_RST_EV;
        ev[`MTEL_EV_UPDATE] = upd_take;
        ev[`MTEL_EV_STATE_CHG] = code_chg;
        ev[`MTEL_EV_FAULT] = fault_in;
        ev[`MTEL_EV_DROPPED] = upd_drop;
    end
    assign bus.ev = ev;

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_sel = mtel_decode(bus.addr);
        bus.rdata = `MTEL_RST_WORD;
        unique case (rd_sel)
            MTEL_REG_STATE: begin
                bus.rdata = widen_code(st_r.code);
            end
            MTEL_REG_SPEED: begin
                bus.rdata = st_r.speed;
            end
            MTEL_REG_BUS_CUR: begin
                bus.rdata = st_r.bus_cur;
            end
            MTEL_REG_PHASE_A: begin
                bus.rdata = st_r.phase_a;
            end
            MTEL_REG_PHASE_B: begin
                bus.rdata = st_r.phase_b;
            end
            MTEL_REG_IRQ_STATUS: begin
                bus.rdata = {28'h0000000, bus.status};
            end
            MTEL_REG_IRQ_MASK: begin
                bus.rdata = {28'h0000000, bus.mask};
            end
            MTEL_REG_CTRL: begin
                bus.rdata = {31'h00000000, st_r.freeze};
            end
            MTEL_REG_UPD_COUNT: begin
                bus.rdata = {16'h0000, st_r.upd_cnt};
            end
            MTEL_REG_NONE: begin
                bus.rdata = `MTEL_RST_WORD;
            end
        endcase
    end

    // next state: snapshot capture, freeze control, update counter
    always_comb begin
        st_nxt = st_r;
        wr_sel = mtel_decode(bus.addr);
        // all five values land on one edge so no read can see a mix
        if (upd_take) begin
            st_nxt.code = alg_state_i;
            st_nxt.speed = alg_speed_i;
            st_nxt.bus_cur = alg_bus_cur_i;
            st_nxt.phase_a = alg_phase_a_i;
            st_nxt.phase_b = alg_phase_b_i;
            st_nxt.upd_cnt = st_r.upd_cnt + 16'h0001; // wraps, software diffs it
        end
        // only the control word is writable here; telemetry writes are ignored
        if (bus.wr_stb && bus.sel[0] && (wr_sel == MTEL_REG_CTRL)) begin
            st_nxt.freeze = bus.wdata[`MTEL_CTRL_FREEZE];
        end
    end

    // synchronous reset clears every telemetry word to zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{code: `MTEL_RST_CODE,
                      speed: `MTEL_RST_WORD,
                      bus_cur: `MTEL_RST_WORD,
                      phase_a: `MTEL_RST_WORD,
                      phase_b: `MTEL_RST_WORD,
                      freeze: 1'b0,
                      upd_cnt: `MTEL_RST_CNT};
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// file: sim/mtel_tel_monitor.sv
// port checker for the telemetry bank
`timescale 1ns/10ps
`default_nettype none
module mtel_tel_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic alg_upd_i,
    input wire logic [15:0] alg_state_i,
    input wire logic [31:0] alg_speed_i,
    input wire logic [31:0] alg_bus_cur_i,
    input wire logic [31:0] alg_phase_a_i,
    input wire logic [31:0] alg_phase_b_i
);
    logic frz_r;
    logic [143:0] sh_r;
    logic [143:0] pv_r;
    logic rd;
    assign rd = wb_ack_o && !wb_we_i;
    // shadow of the last update taken; pv_r is what a read launched last cycle saw
    always_ff @(posedge clk_i) begin
        pv_r <= sh_r;
        if (rst_i) begin
            frz_r <= 1'b0;
            sh_r <= 144'h0;
        end else begin
            if (wb_ack_o && wb_we_i && wb_adr_i == 16'h1fc8 && wb_sel_i[0]) begin
                frz_r <= wb_dat_i[0];
            end
            if (alg_upd_i && !frz_r) begin
                sh_r <= {alg_state_i, alg_speed_i, alg_bus_cur_i, alg_phase_a_i, alg_phase_b_i};
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_state_read: assert property (rd && wb_adr_i == 16'h0640 |->
        wb_dat_o == {16'h0000, pv_r[143:128]}) else $error("state word wrong");
    a_speed_read: assert property (rd && wb_adr_i == 16'h0658 |->
        wb_dat_o == pv_r[127:96]) else $error("speed word wrong");
    a_bus_read: assert property (rd && wb_adr_i == 16'h1040 |->
        wb_dat_o == pv_r[95:64]) else $error("bus current word wrong");
    a_pha_read: assert property (rd && wb_adr_i == 16'h1100 |->
        wb_dat_o == pv_r[63:32]) else $error("first phase word wrong");
    a_phb_read: assert property (rd && wb_adr_i == 16'h1108 |->
        wb_dat_o == pv_r[31:0]) else $error("second phase word wrong");
    a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
        wb_dat_o == 32'h0 && !wb_ack_o && !irq_o) else $error("outputs not cleared");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o ##1 !wb_ack_o) else $error("ack not a single answer");
    a_ack_cause: assert property ($rose(wb_ack_o) |->
        $past(wb_stb_i) && $past(wb_cyc_i)) else $error("ack without request");
    c_frozen_upd: cover property (alg_upd_i && frz_r);
    c_irq_up: cover property ($rose(irq_o));
    c_phb_read: cover property (rd && wb_adr_i == 16'h1108);
endmodule
bind mtel_top mtel_tel_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .alg_upd_i(alg_upd_i), .alg_state_i(alg_state_i), .alg_speed_i(alg_speed_i),
    .alg_bus_cur_i(alg_bus_cur_i), .alg_phase_a_i(alg_phase_a_i),
    .alg_phase_b_i(alg_phase_b_i));
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the telemetry register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [15:0] AD [5] = '{16'h0640, 16'h0658, 16'h1040, 16'h1100, 16'h1108};
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic alg_upd_i = 1'b0, wb_ack_o, irq_o;
    logic [15:0] wb_adr_i = 16'h0, alg_state_i = 16'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, alg_speed_i = 32'h0, alg_bus_cur_i = 32'h0;
    logic [31:0] alg_phase_a_i = 32'h0, alg_phase_b_i = 32'h0, wb_dat_o, rd;
    logic [31:0] e [5] = '{5{32'h0}};
    int n_mismatch = 0, checked = 0, cyc_n = 0;
    mtel_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .alg_upd_i(alg_upd_i),
        .alg_state_i(alg_state_i), .alg_speed_i(alg_speed_i), .alg_bus_cur_i(alg_bus_cur_i),
        .alg_phase_a_i(alg_phase_a_i), .alg_phase_b_i(alg_phase_b_i));
    // 25 MHz clock
    always #20 clk_i = ~clk_i;
    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x, input string nm);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wbx(input logic we, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // one-cycle update pulse; tk says whether the bank should take it
    task automatic upd(input logic [15:0] s, input logic [31:0] v, input logic tk);
        @(posedge clk_i);
        alg_upd_i <= 1'b1;
        alg_state_i <= s;
        alg_speed_i <= v;
        alg_bus_cur_i <= ~v;
        alg_phase_a_i <= v ^ 32'h5a5a_0ff0;
        alg_phase_b_i <= {v[15:0], v[31:16]};
        @(posedge clk_i);
        alg_upd_i <= 1'b0;
        if (tk) e = '{{16'h0000, s}, v, ~v, v ^ 32'h5a5a_0ff0, {v[15:0], v[31:16]}};
    endtask
    task automatic rdall();
        for (int i = 0; i < 5; i++) begin
            wbx(1'b0, AD[i], 32'h0);
            chk(rd, e[i], "telemetry word");
        end
    endtask
    // irq is registered, so look two edges after the cause
    task automatic irq_is(input logic x);
        repeat (2) @(negedge clk_i);
        chk({31'h0, irq_o}, {31'h0, x}, "irq");
    endtask
    // every word, own register and the irq line read zero after a reset
    task automatic zero_all();
        rdall();
        for (int i = 0; i < 4; i++) begin
            wbx(1'b0, 16'h1fc0 + 16'(4 * i), 32'h0);
            chk(rd, 32'h0, "own register");
        end
        irq_is(1'b0);
    endtask
    task automatic t_reset();
        zero_all();
        wbx(1'b0, 16'h0642, 32'h0);
        chk(rd, 32'h0, "misaligned read");
        wbx(1'b0, 16'h0004, 32'h0);
        chk(rd, 32'h0, "unmapped read");
    endtask
    // reset in mid-run must clear words that already hold data
    task automatic t_rerun();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        e = '{5{32'h0}};
        zero_all();
    endtask
    // every state code, then read-only words ignore writes
    task automatic t_codes();
        for (int c = 0; c < 25; c++) begin
            upd(c[15:0], {c[15:0], 16'h5a0f}, 1'b1);
            wbx(1'b0, AD[0], 32'h0);
            chk(rd, e[0], "state code");
        end
        for (int i = 0; i < 5; i++) wbx(1'b1, AD[i], 32'hffff_ffff);
        rdall();
        wbx(1'b0, 16'h1fc0, 32'h0);
        chk(rd, 32'h7, "status after codes");
        wbx(1'b0, 16'h1fcc, 32'h0);
        chk(rd, 32'h19, "update count");
    endtask
    task automatic t_irq();
        wbx(1'b1, 16'h1fc4, 32'h1);
        irq_is(1'b1);
        wbx(1'b1, 16'h1fc0, 32'hf);
        wbx(1'b0, 16'h1fc0, 32'h0);
        chk(rd, 32'h0, "status cleared");
        irq_is(1'b0);
        wbx(1'b1, 16'h1fc4, 32'h0);
        upd(16'h0018, 32'h8000_0001, 1'b1);
        wbx(1'b0, 16'h1fc0, 32'h0);
        chk(rd, 32'h1, "status update only");
        irq_is(1'b0);
        wbx(1'b1, 16'h1fc4, 32'hf);
        irq_is(1'b1);
        // a write without byte lane 0 leaves the mask alone
        @(posedge clk_i);
        wb_sel_i <= 4'he;
        wbx(1'b1, 16'h1fc4, 32'h0);
        wb_sel_i <= 4'hf;
        wbx(1'b0, 16'h1fc4, 32'h0);
        chk(rd, 32'hf, "mask lane guard");
        irq_is(1'b1);
    endtask
    // frozen snapshot keeps all words from one update
    task automatic t_freeze();
        wbx(1'b1, 16'h1fc0, 32'hf);
        wbx(1'b1, 16'h1fc8, 32'h1);
        upd(16'h0005, 32'h1234_5678, 1'b0);
        wbx(1'b0, 16'h1fc0, 32'h0);
        chk(rd, 32'h8, "dropped flag");
        rdall();
        wbx(1'b1, 16'h1fc8, 32'h0);
        upd(16'h000e, 32'hdead_0042, 1'b1);
        rdall();
        wbx(1'b0, 16'h1fc0, 32'h0);
        chk(rd, 32'hf, "status after fault");
        wbx(1'b0, 16'h1fcc, 32'h0);
        chk(rd, 32'h1b, "update count");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_codes();
        t_irq();
        t_freeze();
        t_rerun();
        results();
    end
endmodule
`default_nettype wire
